// ==== include/crc_i2c_port_consts.vh ====
// constants shared by the crc checked i2c register port
`ifndef CRC_I2C_PORT_CONSTS_VH
`define CRC_I2C_PORT_CONSTS_VH
// =====================================================
// clock and spike filter timing
`define CLK_PERIOD_NS   10
`define SPIKE_LS_NS     50
`define SPIKE_HS_NS     10
// =====================================================
// frame layout
`define TARGET_FIX      2'b01
`define REG_PAD         2'b00
`define DOM_MAIN        1'b0
`define RW_READ         1'b1
`define BITS_PER_BYTE   4'h8
`define ACK_SLOT        4'h8
`define ACK_DONE        4'h9
`define BYTE_HI         2'h0
`define BYTE_LO         2'h1
`define BYTE_CRC        2'h2
`define BYTE_PAST       2'h3
`define IDLE_BYTE       8'hff
// =====================================================
// crc parameters
`define CRC_SEED        8'hff
`define CRC_POLY        8'h1d
// =====================================================
// register store size
`define MEM_AW          7
`define MEM_DEPTH       128
`endif

// ==== hw/reg_store_mem.v ====
// register store for both domains, one write port, registered read
`timescale 1ns/1ps
`include "crc_i2c_port_consts.vh"
module reg_store_mem (
   input  wire                clk_i,    // system clock
   input  wire                we_i,     // write strobe
   input  wire [`MEM_AW-1:0]  waddr_i,  // write address, domain in msb
   input  wire [15:0]         wdata_i,  // write data
   input  wire [`MEM_AW-1:0]  raddr_i,  // read address
   output reg  [15:0]         rdata_o   // read data, one cycle late
);
   // =====================================================
   // storage, no reset so it maps onto plain ram
   reg [15:0] mem_q [0:`MEM_DEPTH-1];  // register words

   // write and registered read
   always @(posedge clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule

// ==== hw/crc_i2c_port.v ====
// i2c target port with crc protected 16-bit register frames
`timescale 1ns/1ps
`include "crc_i2c_port_consts.vh"
module crc_i2c_port (
   input  wire        clk_i,           // 100 MHz system clock
   input  wire        rst_n_i,         // async reset, active low
   input  wire        scl_i,           // bus clock pin level
   input  wire        sda_i,           // bus data pin level
   output reg         sda_o,           // data pin output value, always low
   output reg         sda_oe_n_o,      // low while pulling data low
   input  wire [3:0]  target_id_field, // programmed address bits, static
   input  wire        hs_mode_i,       // selects the short spike filter
   input  wire        comm_err_clr_i,  // clears the error flag
   output reg         comm_err_o       // sticky communication error
);
   // =====================================================
   // timing derived from the clock rate, least times round up
   localparam integer LS_CYC_N = (`SPIKE_LS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer HS_CYC_N = (`SPIKE_HS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   // counts stay small, so only the low bits are kept on purpose
   localparam [2:0]   LS_CYC   = LS_CYC_N[2:0];
   localparam [2:0]   HS_CYC   = HS_CYC_N[2:0];

   // one-hot protocol states
   localparam [4:0] ST_IDLE = 5'h01;  // waiting for start
   localparam [4:0] ST_ADDR = 5'h02;  // target address byte
   localparam [4:0] ST_REG  = 5'h04;  // register address byte
   localparam [4:0] ST_WDAT = 5'h08;  // write data and crc
   localparam [4:0] ST_RDAT = 5'h10;  // read data and crc out

   // =====================================================
   // crc over one byte, bit-serial unrolled, msb first
   function [7:0] crc_byte;
      input [7:0] crc;
      input [7:0] data;
      integer     i;
      reg   [7:0] c;
      begin
         c = crc;
         for (i = 7; i >= 0; i = i - 1) begin
            c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
         end
         crc_byte = c;
      end
   endfunction

   // =====================================================
   // pin synchronisers and spike filters
   reg  [2:0] scl_sync_q;   // three stage scl chain
   reg  [2:0] sda_sync_q;   // three stage sda chain
   reg  [2:0] scl_cnt_q;    // scl stable count
   reg  [2:0] sda_cnt_q;    // sda stable count
   reg        scl_f_q;      // filtered scl
   reg        sda_f_q;      // filtered sda
   reg        scl_d1_q;     // previous filtered scl
   reg        sda_d1_q;     // previous filtered sda
   wire [2:0] filt_lim = hs_mode_i ? HS_CYC : LS_CYC;

   // a new level must hold filt_lim cycles, so shorter spikes vanish
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         scl_cnt_q  <= 3'h0;
         sda_cnt_q  <= 3'h0;
         scl_f_q    <= 1'b1;
         sda_f_q    <= 1'b1;
         scl_d1_q   <= 1'b1;
         sda_d1_q   <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
         scl_d1_q   <= scl_f_q;
         sda_d1_q   <= sda_f_q;
         // scl filter, only stages two and three are looked at
         if (scl_sync_q[1] == scl_sync_q[2] && scl_sync_q[2] != scl_f_q) begin
            if (scl_cnt_q + 3'h1 >= filt_lim) begin
               scl_f_q   <= scl_sync_q[2];
               scl_cnt_q <= 3'h0;
            end else begin
               scl_cnt_q <= scl_cnt_q + 3'h1;
            end
         end else begin
            scl_cnt_q <= 3'h0;
         end
         // sda filter, same scheme
         if (sda_sync_q[1] == sda_sync_q[2] && sda_sync_q[2] != sda_f_q) begin
            if (sda_cnt_q + 3'h1 >= filt_lim) begin
               sda_f_q   <= sda_sync_q[2];
               sda_cnt_q <= 3'h0;
            end else begin
               sda_cnt_q <= sda_cnt_q + 3'h1;
            end
         end else begin
            sda_cnt_q <= 3'h0;
         end
      end
   end

   // bus events on the filtered lines
   wire scl_rise = scl_f_q & ~scl_d1_q;              // data sample point
   wire scl_fall = ~scl_f_q & scl_d1_q;              // data change point
   wire start_ev = scl_f_q & scl_d1_q & ~sda_f_q & sda_d1_q;
   wire stop_ev  = scl_f_q & scl_d1_q & sda_f_q & ~sda_d1_q;

   // =====================================================
   // protocol state
   reg  [4:0]  state_q;     // protocol state
   reg  [3:0]  bitcnt_q;    // bits of current byte, 8/9 = ack slot
   reg  [1:0]  bytecnt_q;   // data byte index
   reg  [7:0]  shift_q;     // receive shift register
   reg  [7:0]  crc_q;       // running receive crc
   reg  [7:0]  tx_crc_q;    // crc of the read reply
   reg  [7:0]  tx_byte_q;   // byte being sent
   reg         dom_q;       // selected domain
   reg         rw_q;        // read when set
   reg         ack_q;       // pull low in this ack slot
   reg  [5:0]  raddr_q;     // register pointer
   reg  [15:0] wdat_q;      // collected write data
   reg         we_q;        // store write strobe
   reg         err_set_q;   // crc mismatch pulse
   wire [15:0] rdata;       // store read data
   wire [7:0]  reg_byte = {`REG_PAD, raddr_q};

   // address match: fixed 01, programmed id, domain in bit 1, read/write in lsb
   wire addr_hit = (shift_q[7:6] == `TARGET_FIX) && (shift_q[5:2] == target_id_field);

   // byte level receive and transmit machine
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q    <= ST_IDLE;
         bitcnt_q   <= 4'h0;
         bytecnt_q  <= `BYTE_HI;
         shift_q    <= 8'h00;
         crc_q      <= `CRC_SEED;
         tx_crc_q   <= `CRC_SEED;
         tx_byte_q  <= `IDLE_BYTE;
         dom_q      <= `DOM_MAIN;
         rw_q       <= 1'b0;
         ack_q      <= 1'b0;
         raddr_q    <= 6'h00;
         wdat_q     <= 16'h0000;
         we_q       <= 1'b0;
         err_set_q  <= 1'b0;
         sda_o      <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end else begin
         we_q      <= 1'b0;
         err_set_q <= 1'b0;
         if (start_ev) begin
            // start or repeated start restarts the frame and its crc
            state_q    <= ST_ADDR;
            bitcnt_q   <= 4'h0;
            bytecnt_q  <= `BYTE_HI;
            crc_q      <= `CRC_SEED;
            sda_oe_n_o <= 1'b1;
         end else if (stop_ev) begin
            state_q    <= ST_IDLE;
            sda_oe_n_o <= 1'b1;
         end else if (state_q != ST_IDLE) begin
            if (scl_rise) begin
               // sample sda, master ack bit in read slot
               if (bitcnt_q < `BITS_PER_BYTE) begin
                  shift_q  <= {shift_q[6:0], sda_f_q};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (state_q == ST_RDAT && sda_f_q) begin
                  state_q <= ST_IDLE; // master nack ends the reply
               end
            end else if (scl_fall) begin
               if (bitcnt_q == `ACK_SLOT) begin
                  bitcnt_q <= `ACK_DONE;
                  ack_q    <= 1'b0;
                  case (state_q)
                     ST_ADDR: begin
                        if (addr_hit) begin
                           dom_q <= shift_q[1];
                           rw_q  <= shift_q[0];
                           crc_q <= crc_byte(crc_q, shift_q);
                           ack_q <= 1'b1;
                           // reply crc covers address, pointer and data
                           tx_crc_q <= crc_byte(crc_byte(crc_byte(crc_byte(crc_q, shift_q), reg_byte),
                                                rdata[15:8]), rdata[7:0]);
                        end else begin
                           state_q <= ST_IDLE; // other target, stay silent
                        end
                     end
                     ST_REG: begin
                        raddr_q <= shift_q[5:0];
                        crc_q   <= crc_byte(crc_q, shift_q);
                        ack_q   <= 1'b1;
                     end
                     ST_WDAT: begin
                        case (bytecnt_q)
                           `BYTE_HI: begin
                              wdat_q[15:8] <= shift_q;
                              crc_q        <= crc_byte(crc_q, shift_q);
                              ack_q        <= 1'b1;
                           end
                           `BYTE_LO: begin
                              wdat_q[7:0] <= shift_q;
                              crc_q       <= crc_byte(crc_q, shift_q);
                              ack_q       <= 1'b1;
                           end
                           `BYTE_CRC: begin
                              // a wrong check byte is nacked and the write dropped
                              if (shift_q == crc_q) begin
                                 we_q  <= 1'b1;
                                 ack_q <= 1'b1;
                              end else begin
                                 err_set_q <= 1'b1;
                              end
                           end
                           default: begin
                              ack_q <= 1'b0; // extra bytes are nacked
                           end
                        endcase
                        if (bytecnt_q != `BYTE_PAST) begin
                           bytecnt_q <= bytecnt_q + 2'h1;
                        end
                     end
                     default: begin
                        ack_q <= 1'b0; // read slot belongs to the master
                     end
                  endcase
                  sda_oe_n_o <= (state_q == ST_RDAT);
                  if (state_q == ST_RDAT) begin
                     sda_oe_n_o <= 1'b1;
                  end else begin
                     sda_oe_n_o <= ~((state_q == ST_ADDR && addr_hit) || state_q == ST_REG ||
                                     (state_q == ST_WDAT && (bytecnt_q < `BYTE_CRC ||
                                     (bytecnt_q == `BYTE_CRC && shift_q == crc_q))));
                  end
               end else if (bitcnt_q == `ACK_DONE) begin
                  // leave ack slot, pick next phase
                  bitcnt_q   <= 4'h0;
                  sda_oe_n_o <= 1'b1;
                  case (state_q)
                     ST_ADDR: begin
                        if (rw_q == `RW_READ) begin
                           state_q    <= ST_RDAT;
                           bytecnt_q  <= `BYTE_LO;
                           tx_byte_q  <= rdata[15:8];
                           sda_oe_n_o <= rdata[15];
                        end else begin
                           state_q <= ST_REG;
                        end
                     end
                     ST_REG:  state_q <= ST_WDAT;
                     ST_RDAT: begin
                        case (bytecnt_q)
                           `BYTE_LO: begin
                              tx_byte_q  <= rdata[7:0];
                              sda_oe_n_o <= rdata[7];
                           end
                           `BYTE_CRC: begin
                              tx_byte_q  <= tx_crc_q;
                              sda_oe_n_o <= tx_crc_q[7];
                           end
                           default: begin
                              tx_byte_q  <= `IDLE_BYTE;
                              sda_oe_n_o <= 1'b1;
                           end
                        endcase
                        if (bytecnt_q != `BYTE_PAST) begin
                           bytecnt_q <= bytecnt_q + 2'h1;
                        end
                     end
                     default: state_q <= state_q;
                  endcase
               end else if (state_q == ST_RDAT) begin
                  // next reply bit, msb first, released for a one
                  sda_oe_n_o <= tx_byte_q[3'h7 - bitcnt_q[2:0]];
               end
            end
         end
      end
   end

   // =====================================================
   // error flag, a new mismatch wins over a clear
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         comm_err_o <= 1'b0;
      end else if (err_set_q) begin
         comm_err_o <= 1'b1;
      end else if (comm_err_clr_i) begin
         comm_err_o <= 1'b0;
      end
   end

   // =====================================================
   // register store, domain bit above the 6-bit pointer
   reg_store_mem u_store (
      .clk_i   (clk_i),
      .we_i    (we_q),
      .waddr_i ({dom_q, raddr_q}),
      .wdata_i (wdat_q),
      .raddr_i ({dom_q, raddr_q}),
      .rdata_o (rdata)
   );
endmodule

// ==== tb/crc_i2c_port_props.sv ====
// checker for the crc checked i2c register port
`timescale 1ns/1ps
module crc_i2c_port_props (
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_n_o,
   input wire logic [3:0] target_id_field,
   input wire logic       hs_mode_i,
   input wire logic       comm_err_clr_i,
   input wire logic       comm_err_o
);
   // ==========================
   // helper: length of current scl high spell
   logic [4:0] scl_hi_cnt_q; // saturates, long spell means idle bus
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_hi_cnt_q <= 5'h00;
      end else if (!scl_i) begin
         scl_hi_cnt_q <= 5'h00;
      end else if (scl_hi_cnt_q != 5'h1f) begin
         scl_hi_cnt_q <= scl_hi_cnt_q + 5'h01;
      end
   end
   // ==========================
   // properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_drive_start; $fell(sda_oe_n_o); endsequence
   sequence s_drive_held; !sda_oe_n_o [*5]; endsequence
   property p_sda_low; sda_o == 1'b0; endproperty
   property p_reset_exit; $rose(rst_n_i) |-> sda_oe_n_o && !comm_err_o; endproperty
   property p_idle_released; scl_hi_cnt_q > 5'h14 |-> sda_oe_n_o; endproperty
   property p_drive_held; s_drive_start |-> s_drive_held; endproperty
   // device moves data only shortly after a pin clock fall
   property p_move_low; $changed(sda_oe_n_o) |-> !$past(scl_i, 2) || !$past(scl_i, 3); endproperty
   property p_err_sticky; comm_err_o && !comm_err_clr_i |=> comm_err_o; endproperty
   property p_err_clear; comm_err_clr_i && scl_hi_cnt_q > 5'h14 |=> !comm_err_o; endproperty
   property p_err_nack; $rose(comm_err_o) |-> sda_oe_n_o && $past(sda_oe_n_o); endproperty
   a_sda_low: assert property (p_sda_low) else $error("sda value not low");
   a_reset_exit: assert property (p_reset_exit) else $error("outputs busy after reset");
   a_idle_released: assert property (p_idle_released) else $error("data held on idle bus");
   a_drive_held: assert property (p_drive_held) else $error("drive too short");
   a_move_low: assert property (p_move_low) else $error("data moved in clock high");
   a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");
   a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");
   a_err_nack: assert property (p_err_nack) else $error("error with acked crc");
endmodule
bind crc_i2c_port crc_i2c_port_props i_crc_i2c_port_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .target_id_field(target_id_field),
   .hs_mode_i(hs_mode_i), .comm_err_clr_i(comm_err_clr_i), .comm_err_o(comm_err_o));

// ==== tb/i2c_ctl_model.sv ====
// bus controller model framing bytes on the clock and data wires
`timescale 1ns/1ps
module i2c_ctl_model (
   output logic scl_o,      // bus clock, high between frames
   output logic sda_oe_n_o, // low while pulling data low
   input  wire  sda_i       // resolved data wire
);
   int   t_ns   = 10;   // phase unit: low 5 units, high 3 units
   logic glitch = 1'b0; // 30 ns clock dip inside each bit's high phase
   initial begin
      scl_o      = 1'b1;
      sda_oe_n_o = 1'b1;
   end
   // ==========================
   // one bit: data moves in low phase, read just before the fall
   task automatic bit_cycle(input logic b, output logic r);
      #(2 * t_ns) sda_oe_n_o = b;
      #(3 * t_ns) scl_o = 1'b1;
      if (glitch) begin
         #(t_ns) scl_o = 1'b0;
         #30 scl_o = 1'b1;
         #(2 * t_ns - 30);
      end else begin
         #(3 * t_ns);
      end
      r = sda_i;
      scl_o = 1'b0;
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      #(2 * t_ns) sda_oe_n_o = 1'b1;
      #(3 * t_ns) scl_o = 1'b1;
      #(3 * t_ns) sda_oe_n_o = 1'b0;
      #(3 * t_ns) scl_o = 1'b0;
   endtask
   // stop: data rises while clock high, clock then stands
   task automatic stop();
      #(2 * t_ns) sda_oe_n_o = 1'b0;
      #(3 * t_ns) scl_o = 1'b1;
      #(3 * t_ns) sda_oe_n_o = 1'b1;
      #(3 * t_ns);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(b[i], r);
      end
      bit_cycle(1'b1, r);
      ack = ~r;
   endtask
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, d[i]);
      end
      bit_cycle(~ack, r);
   endtask
endmodule

// ==== tb/crc_checked_i2c_register_port_tb_top.sv ====
// testbench top for the crc checked i2c register port
`timescale 1ns/1ps
module crc_checked_i2c_register_port_tb_top;
   // ==========================
   // clock, reset and pins
   logic       clk_i           = 1'b0;
   logic       rst_n_i         = 1'b0;
   logic [3:0] target_id_field = 4'h0;
   logic       hs_mode_i       = 1'b1;
   logic       comm_err_clr_i  = 1'b0;
   wire        scl_w;
   wire        host_oe_n;
   wire        dev_oe_n;
   wire        sda_w = host_oe_n & dev_oe_n; // pulled up, any puller wins
   wire        comm_err_o;
   int         errors    = 0;
   int         cmp_count = 0;
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   crc_i2c_port i_crc_i2c_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(),
      .sda_oe_n_o(dev_oe_n), .target_id_field(target_id_field), .hs_mode_i(hs_mode_i),
      .comm_err_clr_i(comm_err_clr_i), .comm_err_o(comm_err_o));
   i2c_ctl_model i_i2c_ctl_model (.scl_o(scl_w), .sda_oe_n_o(host_oe_n), .sda_i(sda_w));
   // ==========================
   // shared helpers
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
      end
   endtask
   // serial reference, msb first, all ones seed
   function automatic logic [7:0] crc8(input logic [31:0] f);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? 8'h1d : 8'h00);
      end
      return c;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [5:0] r, input logic [15:0] d, input logic [7:0] c,
                     input logic [4:0] exp_ak);
      logic [4:0] ak;
      i_i2c_ctl_model.start();
      i_i2c_ctl_model.put_byte(a, ak[4]);
      i_i2c_ctl_model.put_byte({2'b00, r}, ak[3]);
      i_i2c_ctl_model.put_byte(d[15:8], ak[2]);
      i_i2c_ctl_model.put_byte(d[7:0], ak[1]);
      i_i2c_ctl_model.put_byte(c, ak[0]);
      i_i2c_ctl_model.stop();
      check({11'h000, ak}, {11'h000, exp_ak});
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [5:0] r, input logic [15:0] exp);
      logic [2:0]  ak;
      logic [15:0] d;
      logic [7:0]  c;
      i_i2c_ctl_model.start();
      i_i2c_ctl_model.put_byte(a, ak[2]);
      i_i2c_ctl_model.put_byte({2'b00, r}, ak[1]);
      i_i2c_ctl_model.start();
      i_i2c_ctl_model.put_byte(a | 8'h01, ak[0]);
      i_i2c_ctl_model.get_byte(1'b1, d[15:8]);
      i_i2c_ctl_model.get_byte(1'b1, d[7:0]);
      i_i2c_ctl_model.get_byte(1'b0, c);
      i_i2c_ctl_model.stop();
      check({13'h0000, ak}, 16'h0007);
      check(d, exp);
      check({8'h00, c}, {8'h00, crc8({a | 8'h01, 2'b00, r, exp})});
   endtask
   // ==========================
   // scenarios
   task automatic t_domains();
      wr(8'h40, 6'h02, 16'h0000, 8'h31, 5'h1f);
      wr(8'h40, 6'h01, 16'ha55a, crc8(32'h4001a55a), 5'h1f);
      wr(8'h42, 6'h01, 16'hd00d, 8'h8c, 5'h1f);
      rd_check(8'h40, 6'h02, 16'h0000);
      rd_check(8'h40, 6'h01, 16'ha55a);
      rd_check(8'h42, 6'h01, 16'hd00d);
      $display("test domains done");
   endtask
   task automatic t_addr();
      @(negedge clk_i) target_id_field = 4'ha;
      wr(8'h40, 6'h05, 16'h1234, crc8(32'h40051234), 5'h00);
      wr(8'he8, 6'h05, 16'h1234, crc8(32'he8051234), 5'h00);
      wr(8'h28, 6'h05, 16'h1234, crc8(32'h28051234), 5'h00);
      wr(8'h68, 6'h05, 16'h1234, crc8(32'h68051234), 5'h1f);
      rd_check(8'h68, 6'h05, 16'h1234);
      @(negedge clk_i) target_id_field = 4'h0;
      $display("test address done");
   endtask
   task automatic t_crc_err();
      wr(8'h40, 6'h01, 16'h5555, crc8(32'h40015555) ^ 8'h01, 5'h1e);
      check({15'h0000, comm_err_o}, 16'h0001);
      rd_check(8'h40, 6'h01, 16'ha55a);
      repeat (30) @(negedge clk_i);
      comm_err_clr_i = 1'b1;
      @(negedge clk_i) comm_err_clr_i = 1'b0;
      @(negedge clk_i);
      check({15'h0000, comm_err_o}, 16'h0000);
      $display("test crc error done");
   endtask
   // slow bus, long filter, clock dips that must be swallowed
   task automatic t_slow();
      @(negedge clk_i) hs_mode_i = 1'b0;
      i_i2c_ctl_model.t_ns = 50;
      i_i2c_ctl_model.glitch = 1'b1;
      repeat (10) @(negedge clk_i);
      wr(8'h42, 6'h3f, 16'hbeef, crc8(32'h423fbeef), 5'h1f);
      rd_check(8'h42, 6'h3f, 16'hbeef);
      i_i2c_ctl_model.t_ns = 10;
      i_i2c_ctl_model.glitch = 1'b0;
      @(negedge clk_i) hs_mode_i = 1'b1;
      $display("test slow bus done");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      @(negedge clk_i) rst_n_i = 1'b1;
      repeat (10) @(negedge clk_i);
      t_domains();
      t_addr();
      t_crc_err();
      t_slow();
      give_verdict();
   end
   // watchdog, well past the expected run length
   initial begin
      #800000;
      errors++;
      give_verdict();
   end
endmodule
